/* verilog/bsd_defs.svh */
`ifndef BSD_DEFS_SVH
`define BSD_DEFS_SVH

// APB register byte offsets.
`define BSD_CTRL_OFS      12'h000
`define BSD_ZPTR_OFS      12'h004
`define BSD_DECODE_OFS    12'h008
`define BSD_ADDR_OFS      12'h00c
`define BSD_CLASS_OFS     12'h010
// Control field positions and register reset values.
`define BSD_CTRL_FUSE_LO  0
`define BSD_CTRL_FUSE_HI  1
`define BSD_CTRL_LARGE    2
`define BSD_CTRL_RST      32'h0000_0003
`define BSD_ZPTR_RST      16'h0000
`define BSD_ADDR_RST      13'h0000
// Small variant geometry.
`define BSD_SM_TOP        13'h0fff
`define BSD_SM_NOREAD_BASE 13'h0c00
`define BSD_SM_BOOT_128   13'h0f80
`define BSD_SM_BOOT_256   13'h0f00
`define BSD_SM_BOOT_512   13'h0e00
`define BSD_SM_BOOT_1024  13'h0c00
`define BSD_SM_WORD_LSB   1
`define BSD_SM_PAGE_LSB   6
`define BSD_SM_PAGE_MSB   12
// Large variant geometry.
`define BSD_LG_TOP        13'h1fff
`define BSD_LG_NOREAD_BASE 13'h1c00
`define BSD_LG_BOOT_128   13'h1f80
`define BSD_LG_BOOT_256   13'h1f00
`define BSD_LG_BOOT_512   13'h1e00
`define BSD_LG_BOOT_1024  13'h1c00
`define BSD_LG_WORD_LSB   1
`define BSD_LG_PAGE_LSB   7
`define BSD_LG_PAGE_MSB   13
// Boot size codes in words, as fuse pairs read programmed-low.
`define BSD_SZ_128        11'h080
`define BSD_SZ_256        11'h100
`define BSD_SZ_512        11'h200
`define BSD_SZ_1024       11'h400

`endif

/* verilog/bsd_pkg.sv */
package bsd_pkg;

   typedef enum logic [1:0] {
      BSD_SEC_APP_READ,
      BSD_SEC_APP_NOREAD,
      BSD_SEC_BOOT
   } bsd_section_t;

   typedef struct packed {
      logic [6:0]  pageSelectField;
      logic [5:0]  wordSelectField;
      logic        byteSelect;
   } bsd_zfields_t;

   typedef struct packed {
      logic [12:0] bootStart;
      logic [12:0] appEnd;
      logic [10:0] bootWords;
      logic [5:0]  bootPages;
   } bsd_boot_t;

endpackage : bsd_pkg

/* verilog/boot_section_decode.sv */
`timescale 1ns/1ps
`include "bsd_defs.svh"

// Contract
// - Small variant: fuse pair 11/10/01/00 gives boot 128..1024 words at 0xF80..0xC00.
// - Large variant: boot starts 0x1F80..0x1C00; application ends one below boot start.
// - Small variant: read-while-write 0x000-0xBFF, no-read 0xC00-0xFFF, any boot size.
// - Large variant: read-while-write 0x0000-0x1BFF, no-read 0x1C00-0x1FFF.
// - Small variant: page from Z[12:6], word-in-page from Z[5:1].
// - Large variant: page from Z[13:7], word-in-page from Z[6:1].
// - Z bits above the page field are ignored.
// - Z bit 0 selects the byte within a word for program memory loads.
// - Page field picks erase/write page; word field picks buffer word.
// - Programmed fuse reads zero, unprogrammed reads one; decode uses this polarity.
module boot_section_decode
   import bsd_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b0
) (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   localparam logic [31:0] CtrlRst = `BSD_CTRL_RST;

   // Fuse bits live in a control register; reset leaves both unprogrammed (ones).
   logic         fuseHi_r;
   logic         fuseLo_r;
   logic         large_r;
   logic [15:0]  zPtr_r;
   logic [12:0]  probeAddr_r;
   logic [31:0]  prdata_r;
   logic         pready_r;
   logic         pslverr_r;
   logic [31:0]  rdata_nxt;
   logic         mapped_nxt;
   bsd_boot_t    boot;
   bsd_zfields_t zf;
   bsd_section_t section;
   logic         inBoot;
   logic         inNoRead;
   logic         inFlash;
   logic         accessPhase;

   function automatic bsd_boot_t boot_decode(input logic isLarge, input logic hi,
                                             input logic lo);
      bsd_boot_t b;
      b = '0;
      // A programmed fuse reads zero, so 00 selects the largest boot section.
      case ({hi, lo})
         2'b11: begin
            b.bootWords = `BSD_SZ_128;
            b.bootStart = isLarge ? `BSD_LG_BOOT_128 : `BSD_SM_BOOT_128;
         end
         2'b10: begin
            b.bootWords = `BSD_SZ_256;
            b.bootStart = isLarge ? `BSD_LG_BOOT_256 : `BSD_SM_BOOT_256;
         end
         2'b01: begin
            b.bootWords = `BSD_SZ_512;
            b.bootStart = isLarge ? `BSD_LG_BOOT_512 : `BSD_SM_BOOT_512;
         end
         default: begin
            b.bootWords = `BSD_SZ_1024;
            b.bootStart = isLarge ? `BSD_LG_BOOT_1024 : `BSD_SM_BOOT_1024;
         end
      endcase
      b.appEnd    = b.bootStart - 13'h0001;
      // Both variants print 32-word boot pages, so pages are words over 32.
      b.bootPages = b.bootWords[10:5];
      return b;
   endfunction : boot_decode

   function automatic bsd_zfields_t z_split(input logic isLarge, input logic [15:0] z);
      bsd_zfields_t f;
      f = '0;
      f.byteSelect = z[0];
      if (isLarge) begin
         // The large word field is six bits wide although the page is 32 words;
         // bit 6 is kept as printed, so the page field starts at bit 7.
         f.pageSelectField = z[`BSD_LG_PAGE_MSB:`BSD_LG_PAGE_LSB];
         f.wordSelectField = z[`BSD_LG_PAGE_LSB-1:`BSD_LG_WORD_LSB];
      end else begin
         f.pageSelectField = z[`BSD_SM_PAGE_MSB:`BSD_SM_PAGE_LSB];
         f.wordSelectField = {1'b0, z[`BSD_SM_PAGE_LSB-1:`BSD_SM_WORD_LSB]};
      end
      // Bits above the page field never reach any decode field.
      return f;
   endfunction : z_split

   always_comb begin
      boot = boot_decode(large_r, fuseHi_r, fuseLo_r);
      zf   = z_split(large_r, zPtr_r);
   end

   // Classification is a pure compare, so a new probe address is answered in the
   // same cycle its register updates; no state hides between address and class.
   always_comb begin
      inFlash = large_r ? (probeAddr_r <= `BSD_LG_TOP) : (probeAddr_r <= `BSD_SM_TOP);
      inBoot  = inFlash && (probeAddr_r >= boot.bootStart);
      inNoRead = large_r ? (probeAddr_r >= `BSD_LG_NOREAD_BASE)
                         : (probeAddr_r >= `BSD_SM_NOREAD_BASE);
      inNoRead = inNoRead && inFlash;
      if (inBoot) begin
         section = BSD_SEC_BOOT;
      end else if (inNoRead) begin
         section = BSD_SEC_APP_NOREAD;
      end else begin
         section = BSD_SEC_APP_READ;
      end
   end

   assign accessPhase = psel && penable && !pready_r;

   // Control register: fuse pair and variant select.
   always_ff @(posedge clk) begin
      if (rst) begin
         fuseLo_r <= CtrlRst[`BSD_CTRL_FUSE_LO];
         fuseHi_r <= CtrlRst[`BSD_CTRL_FUSE_HI];
         large_r  <= LARGE_VARIANT;
      end else if (accessPhase && pwrite && paddr == `BSD_CTRL_OFS) begin
         fuseLo_r <= pwdata[`BSD_CTRL_FUSE_LO];
         fuseHi_r <= pwdata[`BSD_CTRL_FUSE_HI];
         large_r  <= pwdata[`BSD_CTRL_LARGE];
      end
   end

   // Pointer and probe address registers.
   always_ff @(posedge clk) begin
      if (rst) begin
         zPtr_r      <= `BSD_ZPTR_RST;
         probeAddr_r <= `BSD_ADDR_RST;
      end else if (accessPhase && pwrite) begin
         if (paddr == `BSD_ZPTR_OFS) begin
            zPtr_r <= pwdata[15:0];
         end
         if (paddr == `BSD_ADDR_OFS) begin
            probeAddr_r <= pwdata[12:0];
         end
      end
   end

   always_comb begin
      rdata_nxt  = 32'h0000_0000;
      mapped_nxt = 1'b1;
      case (paddr)
         `BSD_CTRL_OFS: begin
            rdata_nxt = {29'h0, large_r, fuseHi_r, fuseLo_r};
         end
         `BSD_ZPTR_OFS: begin
            rdata_nxt = {16'h0, zPtr_r};
         end
         `BSD_DECODE_OFS: begin
            rdata_nxt = {2'b00, zf.byteSelect, zf.wordSelectField,
                         1'b0, zf.pageSelectField, 2'b00, boot.bootStart};
         end
         `BSD_ADDR_OFS: begin
            rdata_nxt = {19'h0, probeAddr_r};
         end
         `BSD_CLASS_OFS: begin
            rdata_nxt = {boot.bootPages, 2'b00, boot.appEnd, boot.bootWords};
            rdata_nxt[29] = inFlash;
            rdata_nxt[28] = inNoRead;
            rdata_nxt[27] = inBoot;
            rdata_nxt[26:25] = section;
         end
         default: begin
            mapped_nxt = 1'b0;
         end
      endcase
   end

   // One wait state: pready rises one edge into the access phase, from a flop.
   always_ff @(posedge clk) begin
      if (rst) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0000_0000;
      end else begin
         pready_r  <= accessPhase;
         pslverr_r <= accessPhase && !mapped_nxt;
         if (accessPhase && !pwrite) begin
            prdata_r <= rdata_nxt;
         end
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

endmodule : boot_section_decode

/* bench/bsd_asserts.sv */
`timescale 1ns/1ps
module bsd_asserts (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [11:0] paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   wait_state_a: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready too long");
   ready_cause_a: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("pslverr alone");
   unmapped_err_a: assert property (pready && paddr[1:0] == 2'h0
      |-> pslverr == (paddr > 12'h010)) else $error("pslverr wrong");
   err_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read not zero");
   rdata_hold_a: assert property (!(pready && !pwrite) |-> $stable(prdata))
      else $error("prdata moved");
   zptr_width_a: assert property (pready && !pwrite && paddr == 12'h004
      |-> prdata[31:16] == 16'h0) else $error("pointer too wide");
endmodule : bsd_asserts

/* bench/boot_section_decode_test.sv */
`timescale 1ns/1ps
module boot_section_decode_test;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [31:0] seed = 32'h4baaa234;
   int          miscompares = 0;
   int          checks = 0;
   always #2.5 clk = ~clk;
   boot_section_decode #(.LARGE_VARIANT(1'b0)) dut (.clk(clk), .rst(rst), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   task automatic summarize();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : summarize
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Read data is taken only at the edge where pready is seen high.
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      paddr <= a;
      pwrite <= w;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         summarize();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer
   initial begin
      logic [31:0] r;
      logic [31:0] z;
      logic [31:0] a;
      logic        e;
      int          top;
      int          nrd;
      int          bs;
      int          sec;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      xfer(1'b0, 12'h000, 32'h0, r, e);
      chk("ctrl reset", 32'h3, r & 32'h7);
      xfer(1'b0, 12'h004, 32'h0, r, e);
      chk("zptr reset", 32'h0, r);
      xfer(1'b1, 12'h014, 32'hffff, r, e);
      chk("unmapped err", 32'h1, e);
      xfer(1'b0, 12'h014, 32'h0, r, e);
      chk("unmapped data", 32'h0, r);
      $display("register test done");
      for (int v = 0; v < 2; v++) begin
         for (int f = 0; f < 4; f++) begin
            top = v ? 'h1fff : 'hfff;
            nrd = v ? 'h1c00 : 'hc00;
            bs = top + 1 - (128 << (3 - f));
            z = xs();
            xfer(1'b1, 12'h000, {29'h0, v[0], f[1:0]}, r, e);
            xfer(1'b1, 12'h004, z, r, e);
            xfer(1'b0, 12'h008, 32'h0, r, e);
            chk("boot start", bs, r[12:0]);
            chk("page", v ? z[13:7] : z[12:6], r[21:15]);
            chk("word", v ? z[6:1] : {1'b0, z[5:1]}, r[28:23]);
            chk("byte select", z[0], r[29]);
            xfer(1'b1, 12'h004, z & (v ? 32'hff80 : 32'hffc0), r, e);
            xfer(1'b0, 12'h008, 32'h0, r, e);
            chk("page write word", 32'h0, r[29:23]);
            chk("page write page", v ? z[13:7] : z[12:6], r[21:15]);
            // Probes sit on both sides of the boot-start and no-read boundaries, where an off-by-one shows.
            for (int k = 0; k < 5; k++) begin
               a = k == 0 ? bs : k == 1 ? bs - 1 : k == 2 ? nrd : k == 3 ? nrd - 1
                   : xs() & 32'h1fff;
               sec = a > top ? 0 : a >= bs ? 2 : a >= nrd ? 1 : 0;
               xfer(1'b1, 12'h00c, a, r, e);
               xfer(1'b0, 12'h010, 32'h0, r, e);
               chk("boot words", 128 << (3 - f), r[10:0]);
               chk("app end", bs - 1, r[23:11]);
               chk("class", {a <= top, a <= top && a >= nrd, a <= top && a >= bs,
                   sec[1:0]}, r[29:25]);
            end
         end
      end
      $display("decode test done");
      summarize();
   end
endmodule : boot_section_decode_test
bind boot_section_decode bsd_asserts bsdChecker (.clk(clk), .rst(rst), .paddr(paddr),
   .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr));
